/* File: logic/tmvch_pkg.sv */
package tmvch_pkg;

    // System clock and link timing
    localparam int CLK_HZ = 40_000_000;
    localparam int TOGGLE_RATE_HZ = 30_000;
    // One toggle period holds two pin edges
    localparam int TOGGLE_HALF_CYC = CLK_HZ / (2 * TOGGLE_RATE_HZ);
    // Edge spacing tolerance of +/-25 %, wide enough for a loose host oscillator
    localparam int TOGGLE_MIN_CYC = (TOGGLE_HALF_CYC * 3) / 4;
    localparam int TOGGLE_MAX_CYC = (TOGGLE_HALF_CYC * 5) / 4;
    localparam int TOGGLE_EDGES = 8;
    localparam int BOOT_WINDOW_US = 1000;
    localparam int BOOT_WINDOW_CYC = BOOT_WINDOW_US * (CLK_HZ / 1_000_000);

    // Command field layout
    localparam int OGF_LSB = 10;
    localparam logic [5:0] VENDOR_OGF = 6'h3F;

    // Vendor opcodes
    localparam logic [15:0] OP_SET_PUBLIC_ADDRESS = 16'hFC02;
    localparam logic [15:0] OP_SET_BAUD_RATE = 16'hFC07;
    localparam logic [15:0] OP_TRANSMITTER_TEST = 16'hFC11;
    localparam logic [15:0] OP_TRANSMITTER_TEST_END = 16'hFC12;
    localparam logic [15:0] OP_READ_AT_ADDRESS = 16'hFC20;
    localparam logic [15:0] OP_READ_CONTINUE = 16'hFC21;
    localparam logic [15:0] OP_WRITE_AT_ADDRESS = 16'hFC22;
    localparam logic [15:0] OP_RF_ACTIVITY_SIGNAL = 16'hFC25;
    localparam logic [15:0] OP_PATCH_BEGIN = 16'hFC27;
    localparam logic [15:0] OP_PATCH_CONTINUE = 16'hFC28;
    localparam logic [15:0] OP_PATCH_ABORT = 16'hFC29;

    // Completion status codes
    localparam logic [7:0] ST_SUCCESS = 8'h00;
    localparam logic [7:0] ST_UNKNOWN_CMD = 8'h01;
    localparam logic [7:0] ST_DISALLOWED = 8'h0C;

    // Interrupt enables: bit 0 host transport, bit 1 memory controller
    localparam logic [15:0] PTM_IRQ_KEEP = 16'h0003;
    localparam logic [15:0] IRQ_ALL = 16'hFFFF;
    localparam logic [15:0] IRQ_NONE = 16'h0000;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_SAMPLE = 3'b001,
        BS_HWINIT = 3'b010,
        BS_CONFIG = 3'b011,
        BS_RUN = 3'b100,
        BS_PTM = 3'b101
    } tmvch_boot_e;

    typedef enum logic [1:0] {
        BK_POWERUP = 2'b00,
        BK_RESET = 2'b01,
        BK_RESUME = 2'b10
    } tmvch_kind_e;

    // Vendor group test on the upper six bits
    function automatic logic tmvch_is_vendor(input logic [15:0] op);
        return op[15:OGF_LSB] == VENDOR_OGF;
    endfunction

    // Defined vendor opcode set
    function automatic logic tmvch_defined(input logic [15:0] op);
        logic ok;
        ok = 1'b0;
        case (op)
            16'hFC02, 16'hFC07, 16'hFC11, 16'hFC12, 16'hFC20, 16'hFC21, 16'hFC22,
            16'hFC23, 16'hFC24, 16'hFC25, 16'hFC26, 16'hFC27, 16'hFC28, 16'hFC29,
            16'hFC2A, 16'hFC2B, 16'hFC2C, 16'hFC2D, 16'hFC2E, 16'hFC2F, 16'hFC32,
            16'hFC33, 16'hFC34: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Subset served in production test mode
    function automatic logic tmvch_ptm_ok(input logic [15:0] op);
        logic ok;
        ok = tmvch_defined(op);
        case (op)
            OP_SET_PUBLIC_ADDRESS, OP_SET_BAUD_RATE, OP_TRANSMITTER_TEST,
            OP_TRANSMITTER_TEST_END, OP_RF_ACTIVITY_SIGNAL: ok = 1'b0;
            default: ok = ok;
        endcase
        return ok;
    endfunction

endpackage

/* File: logic/tmvch_tog_if.sv */
`timescale 1ns/100ps
// Link between boot sequencer and entry-pin toggle detector
interface tmvch_tog_if;
    logic arm;
    logic seen;
    modport ctl (output arm, input seen);
    modport det (input arm, output seen);
endinterface

/* File: logic/tmvch_toggle_det.sv */
`timescale 1ns/100ps
module tmvch_toggle_det #(
    parameter int HALF_MIN = tmvch_pkg::TOGGLE_MIN_CYC,
    parameter int HALF_MAX = tmvch_pkg::TOGGLE_MAX_CYC,
    parameter int EDGES = tmvch_pkg::TOGGLE_EDGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin,
    tmvch_tog_if.det tog
);
    localparam int CW = $clog2(HALF_MAX + 2);
    localparam int EW = $clog2(EDGES + 1);

    logic [2:0] sync_reg;
    logic level_reg;
    logic [CW-1:0] gap_reg;
    logic [EW-1:0] good_reg;
    logic seen_reg;
    logic edge_now;

    // Pin synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sync_reg <= 3'b000;
        else
            sync_reg <= {sync_reg[1:0], pin};
    end

    // Level accepted once stages 1 and 2 agree
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            level_reg <= 1'b0;
        else if (sync_reg[1] == sync_reg[2])
            level_reg <= sync_reg[2];
    end

    assign edge_now = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != level_reg);

    // Cycles since last edge, saturating past the window
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gap_reg <= '0;
        else if (!tog.arm || edge_now)
            gap_reg <= '0;
        else if (gap_reg != CW'(HALF_MAX + 1))
            gap_reg <= gap_reg + 1'b1;
    end

    // RULE2 - count well-spaced edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            good_reg <= '0;
        else if (!tog.arm)
            good_reg <= '0;
        else if (edge_now)
        begin
            // First edge only starts timing; a bad gap restarts the run
            if (good_reg == '0 || gap_reg < CW'(HALF_MIN) || gap_reg > CW'(HALF_MAX))
                good_reg <= EW'(1);
            else if (good_reg != EW'(EDGES))
                good_reg <= good_reg + 1'b1;
        end
        else if (gap_reg > CW'(HALF_MAX))
            good_reg <= '0;
    end

    // RULE2 - sticky entry verdict while armed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seen_reg <= 1'b0;
        else if (!tog.arm)
            seen_reg <= 1'b0;
        else if (good_reg == EW'(EDGES))
            seen_reg <= 1'b1;
    end

    assign tog.seen = seen_reg;

    property p_seen_needs_arm;
        @(posedge clk) disable iff (!rst_n)
        $rose(seen_reg) |-> $past(tog.arm) && $past(good_reg) == EW'(EDGES);
    endproperty
    a_seen_needs_arm: assert property (p_seen_needs_arm) // RULE2
        else $error("Entry verdict raised without a full toggle run");

endmodule // tmvch_toggle_det

/* File: logic/tmvch_cmd_handler.sv */
// Functional notes
// RULE1 - Boot flow runs after power-up, reset, and sleep resume events.
// RULE2 - Test mode entered when entry pin toggles at 30 kHz during boot.
// RULE3 - Test mode skips stored configuration and never runs application code.
// RULE4 - Test mode masks every interrupt except those test mode needs.
// RULE5 - Scheduler stays off in test mode; hardware initialised before commands.
// RULE6 - Test mode selects SPI as host command transport.
// RULE7 - Test mode decodes standard commands locally, answers Command Complete.
// RULE8 - Test mode allows memory programming via patch begin, continue, abort.
// RULE9 - Patch begin enters programming state, held until reset or power-down.
// RULE10 - Vendor commands use group 0x3F; opcode is group with command field.
// RULE11 - Outside test mode every defined vendor command goes to link layer.
// RULE12 - Test mode rejects public address, baud rate, transmitter test opcodes.
// RULE13 - Test mode executes read-at-address, read-continue, write-at-address.
// RULE14 - Unsupported vendor command gets error completion, state unchanged.
// RULE15 - Patch continue or abort before patch begin is rejected.
`timescale 1ns/100ps
module tmvch_cmd_handler #(
    parameter int IRQ_W = 16,
    parameter int BOOT_WINDOW_CYC = tmvch_pkg::BOOT_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic boot_req,
    input wire logic [1:0] boot_kind,
    input wire logic test_entry_pin,
    input wire logic hw_init_done,
    input wire logic cfg_done,
    input wire logic cfg_spi_sel,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_opcode,
    output logic cmd_ready,
    output logic test_mode,
    output logic [1:0] boot_kind_out,
    output logic hw_init_start,
    output logic cfg_apply_start,
    output logic app_run_en,
    output logic sched_en,
    output logic [IRQ_W-1:0] irq_en,
    output logic hci_spi_sel,
    output logic ll_cmd_valid,
    output logic [15:0] ll_cmd_opcode,
    output logic exec_valid,
    output logic [15:0] exec_opcode,
    output logic evt_valid,
    output logic [15:0] evt_opcode,
    output logic [7:0] evt_status,
    output logic prog_state
);
    localparam int WW = $clog2(BOOT_WINDOW_CYC + 1);
    logic [1:0] rst_sync_reg, kind_reg;
    logic rst_n_sync, take, vendor, prog_clear, prog_set;
    tmvch_pkg::tmvch_boot_e state_reg;
    logic [WW-1:0] win_reg;
    logic ptm_reg, hw_start_reg, cfg_start_reg, app_reg, sched_reg, spi_reg, ready_reg;
    logic [IRQ_W-1:0] irq_reg;
    logic ll_valid_reg, exec_reg, evt_reg, prog_reg;
    logic [15:0] ll_op_reg, exec_op_reg, evt_op_reg;
    logic [7:0] evt_st_reg;
    tmvch_tog_if tog ();

    // Reset release through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n_sync = rst_sync_reg[1];

    // Entry pin watched only during the boot sampling window
    tmvch_toggle_det u_det (
        .clk(clk),
        .rst_n(rst_n_sync),
        .pin(test_entry_pin),
        .tog(tog.det)
    );
    assign tog.arm = (state_reg == tmvch_pkg::BS_SAMPLE);
    // Boot sequencer; a new boot request restarts from any state
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            state_reg <= tmvch_pkg::BS_IDLE;
            win_reg <= '0;
            ptm_reg <= 1'b0;
            kind_reg <= tmvch_pkg::BK_POWERUP;
            hw_start_reg <= 1'b0;
            cfg_start_reg <= 1'b0;
        end
        else
        begin
            hw_start_reg <= 1'b0;
            cfg_start_reg <= 1'b0;
            // RULE1 - all three start events
            if (boot_req)
            begin
                state_reg <= tmvch_pkg::BS_SAMPLE;
                win_reg <= '0;
                ptm_reg <= 1'b0;
                kind_reg <= boot_kind;
            end
            else
            begin
                case (state_reg)
                    tmvch_pkg::BS_SAMPLE:
                    begin
                        win_reg <= win_reg + 1'b1;
                        // RULE2 - verdict on a full toggle run, else at window end
                        if (tog.seen || win_reg == WW'(BOOT_WINDOW_CYC - 1))
                        begin
                            ptm_reg <= tog.seen;
                            state_reg <= tmvch_pkg::BS_HWINIT;
                            hw_start_reg <= 1'b1;
                        end
                    end
                    tmvch_pkg::BS_HWINIT:
                        // RULE5 - defaults loaded first
                        if (hw_init_done)
                        begin
                            // RULE3 - test mode bypasses stored options
                            if (ptm_reg)
                                state_reg <= tmvch_pkg::BS_PTM;
                            else
                            begin
                                state_reg <= tmvch_pkg::BS_CONFIG;
                                cfg_start_reg <= 1'b1;
                            end
                        end
                    tmvch_pkg::BS_CONFIG:
                        if (cfg_done)
                            state_reg <= tmvch_pkg::BS_RUN;
                    tmvch_pkg::BS_IDLE, tmvch_pkg::BS_RUN, tmvch_pkg::BS_PTM:
                        state_reg <= state_reg;
                    default:
                        state_reg <= tmvch_pkg::BS_IDLE;
                endcase
            end
        end
    end

    // Mode outputs follow the boot state one cycle later
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            app_reg <= 1'b0;
            sched_reg <= 1'b0;
            irq_reg <= IRQ_W'(tmvch_pkg::IRQ_NONE);
            spi_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            // RULE3 - application and scheduler only in normal run
            app_reg <= (state_reg == tmvch_pkg::BS_RUN);
            // RULE5 - scheduler idle in test mode
            sched_reg <= (state_reg == tmvch_pkg::BS_RUN);
            ready_reg <= !boot_req && (state_reg == tmvch_pkg::BS_RUN
                || state_reg == tmvch_pkg::BS_PTM);
            // RULE4 - reduced interrupt set in test mode
            if (state_reg == tmvch_pkg::BS_PTM)
                irq_reg <= IRQ_W'(tmvch_pkg::PTM_IRQ_KEEP);
            else if (state_reg == tmvch_pkg::BS_RUN)
                irq_reg <= IRQ_W'(tmvch_pkg::IRQ_ALL);
            else
                irq_reg <= IRQ_W'(tmvch_pkg::IRQ_NONE);
            // RULE6 - SPI forced in test mode
            spi_reg <= (state_reg == tmvch_pkg::BS_PTM) ? 1'b1 : cfg_spi_sel;
        end
    end

    // RULE10 - vendor group decode
    assign take = cmd_valid && ready_reg;
    assign vendor = tmvch_pkg::tmvch_is_vendor(cmd_opcode);
    // Command dispatch; answers land one cycle after the take
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            ll_valid_reg <= 1'b0;
            ll_op_reg <= 16'h0000;
            exec_reg <= 1'b0;
            exec_op_reg <= 16'h0000;
            evt_reg <= 1'b0;
            evt_op_reg <= 16'h0000;
            evt_st_reg <= tmvch_pkg::ST_SUCCESS;
        end
        else
        begin
            ll_valid_reg <= 1'b0;
            exec_reg <= 1'b0;
            evt_reg <= 1'b0;
            if (take && state_reg == tmvch_pkg::BS_RUN)
            begin
                // RULE11 - link layer owns normal-mode commands
                if (!vendor || tmvch_pkg::tmvch_defined(cmd_opcode))
                begin
                    ll_valid_reg <= 1'b1;
                    ll_op_reg <= cmd_opcode;
                end
                else
                begin
                    // RULE14 - undefined vendor opcode
                    evt_reg <= 1'b1;
                    evt_op_reg <= cmd_opcode;
                    evt_st_reg <= tmvch_pkg::ST_UNKNOWN_CMD;
                end
            end
            else if (take && state_reg == tmvch_pkg::BS_PTM)
            begin
                evt_reg <= 1'b1;
                evt_op_reg <= cmd_opcode;
                // RULE12 - excluded vendor opcodes refused
                if (vendor && !tmvch_pkg::tmvch_ptm_ok(cmd_opcode))
                    evt_st_reg <= tmvch_pkg::ST_UNKNOWN_CMD;
                // RULE15 - no patch session yet
                else if (!prog_reg && (cmd_opcode == tmvch_pkg::OP_PATCH_CONTINUE
                    || cmd_opcode == tmvch_pkg::OP_PATCH_ABORT))
                    evt_st_reg <= tmvch_pkg::ST_DISALLOWED;
                else
                begin
                    // RULE7 - local execution with completion
                    // RULE13 - memory access commands run here
                    exec_reg <= 1'b1;
                    exec_op_reg <= cmd_opcode;
                    evt_st_reg <= tmvch_pkg::ST_SUCCESS;
                end
            end
        end
    end

    // RULE9 - programming state; set wins over clear
    assign prog_set = take && state_reg == tmvch_pkg::BS_PTM
        && cmd_opcode == tmvch_pkg::OP_PATCH_BEGIN;
    assign prog_clear = boot_req && boot_kind != tmvch_pkg::BK_RESUME;
    always_ff @(posedge clk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
            prog_reg <= 1'b0;
        // RULE8 - patch begin opens programming
        else if (prog_set)
            prog_reg <= 1'b1;
        else if (prog_clear)
            prog_reg <= 1'b0;
    end

    // Output drive, all straight from flops
    assign cmd_ready = ready_reg;
    assign test_mode = ptm_reg;
    assign boot_kind_out = kind_reg;
    assign hw_init_start = hw_start_reg;
    assign cfg_apply_start = cfg_start_reg;
    assign app_run_en = app_reg;
    assign sched_en = sched_reg;
    assign irq_en = irq_reg;
    assign hci_spi_sel = spi_reg;
    assign ll_cmd_valid = ll_valid_reg;
    assign ll_cmd_opcode = ll_op_reg;
    assign exec_valid = exec_reg;
    assign exec_opcode = exec_op_reg;
    assign evt_valid = evt_reg;
    assign evt_opcode = evt_op_reg;
    assign evt_status = evt_st_reg;
    assign prog_state = prog_reg;

    property p_boot_start;
        @(posedge clk) disable iff (!rst_n_sync)
        boot_req |=> state_reg == tmvch_pkg::BS_SAMPLE && kind_reg == $past(boot_kind);
    endproperty
    a_boot_start: assert property (p_boot_start) // RULE1
        else $error("Boot request did not start sampling");
    property p_no_app_in_ptm;
        @(posedge clk) disable iff (!rst_n_sync)
        state_reg == tmvch_pkg::BS_PTM |=> !app_reg && !sched_reg && !cfg_start_reg;
    endproperty
    a_no_app_in_ptm: assert property (p_no_app_in_ptm) // RULE3
        else $error("Application or config active in test mode");
    property p_irq_ptm;
        @(posedge clk) disable iff (!rst_n_sync)
        state_reg == tmvch_pkg::BS_PTM |=> irq_reg == IRQ_W'(tmvch_pkg::PTM_IRQ_KEEP);
    endproperty
    a_irq_ptm: assert property (p_irq_ptm) // RULE4
        else $error("Interrupt set wrong in test mode");
    property p_init_before_ptm;
        @(posedge clk) disable iff (!rst_n_sync)
        $rose(state_reg == tmvch_pkg::BS_PTM) |->
            $past(state_reg) == tmvch_pkg::BS_HWINIT && $past(hw_init_done);
    endproperty
    a_init_before_ptm: assert property (p_init_before_ptm) // RULE5
        else $error("Test mode reached without hardware init");
    property p_spi_ptm;
        @(posedge clk) disable iff (!rst_n_sync)
        state_reg == tmvch_pkg::BS_PTM ##1 state_reg == tmvch_pkg::BS_PTM |-> spi_reg;
    endproperty
    a_spi_ptm: assert property (p_spi_ptm) // RULE6
        else $error("SPI not selected in test mode");
    property p_std_complete;
        @(posedge clk) disable iff (!rst_n_sync)
        take && state_reg == tmvch_pkg::BS_PTM && !vendor |=>
            evt_reg && exec_reg && evt_st_reg == tmvch_pkg::ST_SUCCESS && !ll_valid_reg;
    endproperty
    a_std_complete: assert property (p_std_complete) // RULE7
        else $error("Standard command not completed in test mode");
    property p_prog_hold;
        @(posedge clk) disable iff (!rst_n_sync)
        prog_reg && !prog_clear |=> prog_reg;
    endproperty
    a_prog_hold: assert property (p_prog_hold) // RULE9
        else $error("Programming state dropped without reset");
    property p_ll_forward;
        @(posedge clk) disable iff (!rst_n_sync)
        take && state_reg == tmvch_pkg::BS_RUN && tmvch_pkg::tmvch_defined(cmd_opcode)
            |=> ll_valid_reg && ll_op_reg == $past(cmd_opcode) && !evt_reg;
    endproperty
    a_ll_forward: assert property (p_ll_forward) // RULE11
        else $error("Vendor command not forwarded in normal mode");
    property p_ptm_refuse;
        @(posedge clk) disable iff (!rst_n_sync)
        take && state_reg == tmvch_pkg::BS_PTM && (cmd_opcode == tmvch_pkg::OP_TRANSMITTER_TEST
            || cmd_opcode == tmvch_pkg::OP_SET_PUBLIC_ADDRESS)
            |=> evt_reg && evt_st_reg == tmvch_pkg::ST_UNKNOWN_CMD && !exec_reg;
    endproperty
    a_ptm_refuse: assert property (p_ptm_refuse) // RULE12
        else $error("Excluded opcode executed in test mode");
    property p_patch_order;
        @(posedge clk) disable iff (!rst_n_sync)
        take && state_reg == tmvch_pkg::BS_PTM && !prog_reg
            && cmd_opcode == tmvch_pkg::OP_PATCH_CONTINUE
            |=> evt_st_reg == tmvch_pkg::ST_DISALLOWED && !exec_reg && !prog_reg;
    endproperty
    a_patch_order: assert property (p_patch_order) // RULE15
        else $error("Patch continue accepted before patch begin");

endmodule // tmvch_cmd_handler

/* File: test/tmvch_host_model.sv */
`timescale 1ns/100ps
// Host side of the entry pin; it holds its level while not enabled
module tmvch_host_model #(
    parameter real HALF_NS = 16666.7
) (
    input wire logic en,
    output logic pin
);
    initial pin = 1'b0;

    always
    begin
        #(HALF_NS);
        if (en)
            pin = ~pin;
    end
endmodule // tmvch_host_model

/* File: test/tb_test_mode_vendor_cmd_handler.sv */
`timescale 1ns/100ps
module tb_test_mode_vendor_cmd_handler;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic boot_req = 1'b0;
    logic [1:0] boot_kind = 2'b00;
    logic pin;
    logic tog_en = 1'b0;
    logic hw_init_done = 1'b0;
    logic cfg_done = 1'b0;
    logic cfg_spi_sel = 1'b0;
    logic cmd_valid = 1'b0;
    logic [15:0] cmd_opcode = 16'h0000;
    logic cmd_ready, test_mode, hw_init_start, cfg_apply_start, app_run_en, sched_en;
    logic hci_spi_sel, ll_cmd_valid, exec_valid, evt_valid, prog_state;
    logic [1:0] boot_kind_out;
    logic [15:0] irq_en, ll_cmd_opcode, exec_opcode, evt_opcode;
    logic [7:0] evt_status;
    logic cfg_seen = 1'b0;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    tmvch_host_model host (.en(tog_en), .pin(pin));

    // Short window, still longer than nine slow edges
    tmvch_cmd_handler #(.IRQ_W(16), .BOOT_WINDOW_CYC(8000)) dut (
        .clk(clk), .rstn(rstn), .boot_req(boot_req), .boot_kind(boot_kind),
        .test_entry_pin(pin), .hw_init_done(hw_init_done), .cfg_done(cfg_done),
        .cfg_spi_sel(cfg_spi_sel), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
        .cmd_ready(cmd_ready), .test_mode(test_mode), .boot_kind_out(boot_kind_out),
        .hw_init_start(hw_init_start), .cfg_apply_start(cfg_apply_start),
        .app_run_en(app_run_en), .sched_en(sched_en), .irq_en(irq_en),
        .hci_spi_sel(hci_spi_sel), .ll_cmd_valid(ll_cmd_valid),
        .ll_cmd_opcode(ll_cmd_opcode), .exec_valid(exec_valid),
        .exec_opcode(exec_opcode), .evt_valid(evt_valid), .evt_opcode(evt_opcode),
        .evt_status(evt_status), .prog_state(prog_state));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Ceiling against a hung wait, well above two boot windows
    always @(posedge clk)
    begin
        cycles++;
        if (cfg_apply_start === 1'b1)
            cfg_seen = 1'b1;
        if (cycles == 40000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    // Pulses are caught at falling edges, so no edge race
    task automatic wait_pulse(input bit cfg);
        int n;
        n = 0;
        while ((cfg ? cfg_apply_start : hw_init_start) !== 1'b1 && n < 10000)
        begin
            @(negedge clk);
            n++;
        end
        check(cfg ? "cfg_apply_start" : "hw_init_start", 16'(n < 10000), 16'h0001);
    endtask

    task automatic boot(input logic [1:0] kind);
        @(negedge clk);
        boot_kind = kind;
        boot_req = 1'b1;
        @(negedge clk);
        boot_req = 1'b0;
    endtask

    task automatic pulse_in(input bit cfg);
        cfg_done = cfg;
        hw_init_done = !cfg;
        @(negedge clk);
        cfg_done = 1'b0;
        hw_init_done = 1'b0;
    endtask

    // Answer shows in the cycle after the take
    task automatic cmd(input logic [15:0] op, input bit ll, input bit ev, input logic [7:0] st);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        @(negedge clk);
        cmd_valid = 1'b0;
        check("ll_cmd_valid", 16'(ll_cmd_valid), 16'(ll));
        check("exec_valid", 16'(exec_valid), 16'(ev && st == 8'h00));
        check("evt_valid", 16'(evt_valid), 16'(ev));
        if (ev)
            check("evt_status", 16'(evt_status), 16'(st));
        if (ev && st == 8'h00)
            check("exec_opcode", exec_opcode, op);
        if (ll)
            check("ll_cmd_opcode", ll_cmd_opcode, op);
        else
            check("evt_opcode", evt_opcode, op);
    endtask

    task automatic normal_boot();
        boot(2'b01);
        wait_pulse(1'b0);
        check("test_mode", 16'(test_mode), 16'h0000);
        pulse_in(1'b0);
        wait_pulse(1'b1);
        pulse_in(1'b1);
        repeat (2) @(negedge clk);
        check("app_run_en", 16'(app_run_en), 16'h0001);
        check("sched_en", 16'(sched_en), 16'h0001);
        check("irq_en", irq_en, tmvch_pkg::IRQ_ALL);
        check("hci_spi_sel", 16'(hci_spi_sel), 16'h0000);
        check("boot_kind_out", 16'(boot_kind_out), 16'h0001);
        cmd(16'h0c03, 1'b1, 1'b0, 8'h00);
        cmd(tmvch_pkg::OP_SET_PUBLIC_ADDRESS, 1'b1, 1'b0, 8'h00);
        cmd(tmvch_pkg::OP_PATCH_BEGIN, 1'b1, 1'b0, 8'h00);
        cmd(16'hfc30, 1'b0, 1'b1, tmvch_pkg::ST_UNKNOWN_CMD);
    endtask

    task automatic test_boot();
        tog_en = 1'b1;
        cfg_seen = 1'b0;
        boot(2'b00);
        wait_pulse(1'b0);
        check("test_mode", 16'(test_mode), 16'h0001);
        check("cmd_ready", 16'(cmd_ready), 16'h0000);
        pulse_in(1'b0);
        tog_en = 1'b0;
        repeat (2) @(negedge clk);
        check("cmd_ready", 16'(cmd_ready), 16'h0001);
        check("hci_spi_sel", 16'(hci_spi_sel), 16'h0001);
        check("irq_en", irq_en, tmvch_pkg::PTM_IRQ_KEEP);
        check("app_run_en", 16'(app_run_en), 16'h0000);
        check("sched_en", 16'(sched_en), 16'h0000);
        check("cfg_seen", 16'(cfg_seen), 16'h0000);
    endtask

    // Refusals around the patch begin, then the programming state holds
    task automatic test_cmds();
        logic [15:0] ops [14] = '{16'h0c03, 16'hfc02, 16'hfc07, 16'hfc11, 16'hfc12,
            16'hfc20, 16'hfc21, 16'hfc22, 16'hfc28, 16'hfc29, 16'hfc27, 16'hfc28,
            16'hfc29, 16'hfc11};
        logic [7:0] sts [14] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00,
            8'h00, 8'h0c, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h01};
        for (int i = 0; i < 14; i++)
        begin
            cmd(ops[i], 1'b0, 1'b1, sts[i]);
            check("prog_state", 16'(prog_state), 16'(i >= 10));
        end
    endtask

    // Resume keeps the programming state, a plain reset boot drops it
    task automatic boot_kinds();
        boot(2'b10);
        check("prog_state", 16'(prog_state), 16'h0001);
        check("boot_kind_out", 16'(boot_kind_out), 16'h0002);
        check("cmd_ready", 16'(cmd_ready), 16'h0000);
        check("test_mode", 16'(test_mode), 16'h0000);
        boot(2'b01);
        check("prog_state", 16'(prog_state), 16'h0000);
        check("boot_kind_out", 16'(boot_kind_out), 16'h0001);
    endtask

    task automatic reset_clears();
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check("prog_state", 16'(prog_state), 16'h0000);
        check("test_mode", 16'(test_mode), 16'h0000);
    endtask

    initial
    begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        normal_boot();
        test_boot();
        test_cmds();
        boot_kinds();
        reset_clears();
        tally_and_finish();
    end
endmodule // tb_test_mode_vendor_cmd_handler
